// *** cfg_access_client.sv ***
// Client end: decodes configuration read and write requests and answers them
// Notes on behaviour
// - Read: length five, five, code a1
// - Entry chosen by index and parameter
// - Reads return one word, length sets size
// - Read answer starts with completion code
// - Parameter and data go low byte first
// - Mismatched lengths or code give abort check
// - Success with valid data gives 40
// - Late gives 80, no resources 81
// - Invalid gives 90, internal failure 91
// - Write: length ten, one, code a5
// - Valid write stores data into entry
// - Failed assured check: bad check, no store
// - Write answer carries same completion codes
// - Reads use read command, writes write
// - Held data only, no extra polling
// - Checks cover request, then answer data
module cfg_access_client #(
	parameter logic [7:0] CLIENT_ADDR = 8'h30,
	parameter int         NUM_INDEX   = 64,
	parameter int         NUM_PARAM   = 4
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Link
	cfg_link_if.client_end         link,
	// Physical layer flags a corrupted request byte
	input  wire logic              link_fault,
	// Service state
	input  wire logic              busy,
	input  wire logic              no_resource,
	input  wire logic              fault,
	// Local loading of held data
	input  wire logic              load_valid,
	input  wire logic [7:0]        load_index,
	input  wire logic [15:0]       load_param,
	input  wire logic [31:0]       load_data,
	// Report of a committed write
	output logic                   upd_valid,
	output logic      [7:0]        upd_index,
	output logic      [15:0]       upd_param,
	output logic      [31:0]       upd_data
);
	localparam int DEPTH = NUM_INDEX * NUM_PARAM;
	localparam int AW    = $clog2(DEPTH);

	typedef enum logic [1:0] {
		ST_RECV   = 2'b00,
		ST_DECIDE = 2'b01,
		ST_SEND   = 2'b10
	} client_state_t;

	client_state_t         state;
	logic [7:0]            rx_buf [cfg_cmd_pkg::FRAME_DEPTH];
	logic [3:0]            rx_count;
	logic                  rx_err;
	logic [7:0]            prev_crc;
	logic [31:0]           space [DEPTH];
	logic [7:0]            tx_buf [cfg_cmd_pkg::RESP_BYTES];
	logic [7:0]            fcs_first;
	logic [2:0]            tx_k;
	logic [2:0]            tx_last;
	logic                  crc_clear;
	logic                  crc_en;
	logic [7:0]            crc_data;
	logic [7:0]            crc_value;
	logic                  rd_format;
	logic                  wr_format;
	logic                  addr_hit;
	logic                  aw_ok;
	logic                  commit;
	logic [7:0]            req_index;
	logic [15:0]           req_param;
	logic [31:0]           req_data;
	logic [31:0]           held_word;
	logic [7:0]            cc;
	cfg_cmd_pkg::outcome_t verdict;

	function automatic logic entry_valid(input logic [7:0] idx, input logic [15:0] prm);
		return (32'(idx) < 32'(NUM_INDEX)) && (32'(prm) < 32'(NUM_PARAM));
	endfunction

	function automatic logic [AW-1:0] entry_addr(input logic [7:0] idx, input logic [15:0] prm);
		logic [31:0] flat;
		flat = 32'(idx) * 32'(NUM_PARAM) + 32'(prm);
		return flat[AW-1:0];
	endfunction

	frame_check u_check (
		.clk    (clk),
		.arst_n (arst_n),
		.clear  (crc_clear),
		.enable (crc_en),
		.data   (crc_data),
		.value  (crc_value)
	);

	// Request decode
	assign addr_hit  = rx_buf[cfg_cmd_pkg::POS_ADDR] == CLIENT_ADDR;
	assign rd_format = rx_buf[cfg_cmd_pkg::POS_WL] == cfg_cmd_pkg::RD_WL
		&& rx_buf[cfg_cmd_pkg::POS_RL] == cfg_cmd_pkg::RD_RL
		&& rx_buf[cfg_cmd_pkg::POS_CMD] == cfg_cmd_pkg::RD_CMD
		&& rx_count == cfg_cmd_pkg::RD_FRAME;
	assign wr_format = rx_buf[cfg_cmd_pkg::POS_WL] == cfg_cmd_pkg::WR_WL
		&& rx_buf[cfg_cmd_pkg::POS_RL] == cfg_cmd_pkg::WR_RL
		&& rx_buf[cfg_cmd_pkg::POS_CMD] == cfg_cmd_pkg::WR_CMD
		&& rx_count == cfg_cmd_pkg::WR_FRAME;
	// Check value seen just before the last byte arrived
	assign aw_ok     = rx_buf[cfg_cmd_pkg::POS_AW] == (prev_crc ^ cfg_cmd_pkg::AW_XOR);
	assign req_index = rx_buf[cfg_cmd_pkg::POS_INDEX];
	assign req_param = {rx_buf[cfg_cmd_pkg::POS_PMSB], rx_buf[cfg_cmd_pkg::POS_PLSB]};
	assign req_data  = {rx_buf[cfg_cmd_pkg::POS_D3], rx_buf[cfg_cmd_pkg::POS_D2],
		rx_buf[cfg_cmd_pkg::POS_D1], rx_buf[cfg_cmd_pkg::POS_D0]};
	// Answers come from held entries only
	assign held_word = entry_valid(req_index, req_param) ? space[entry_addr(req_index, req_param)] : '0;

	always_comb begin
		if (rx_err) begin
			verdict = cfg_cmd_pkg::OUT_BAD_WRITE;
		end else if (!(rd_format || wr_format)) begin
			verdict = cfg_cmd_pkg::OUT_ABORT;
		end else if (wr_format && !aw_ok) begin
			verdict = cfg_cmd_pkg::OUT_BAD_WRITE;
		end else begin
			verdict = cfg_cmd_pkg::OUT_OK;
		end
	end

	always_comb begin
		if (fault) begin
			cc = cfg_cmd_pkg::CC_FAULT;
		end else if (busy) begin
			cc = cfg_cmd_pkg::CC_TIMEOUT;
		end else if (no_resource) begin
			cc = cfg_cmd_pkg::CC_NO_RES;
		end else if (!entry_valid(req_index, req_param)) begin
			cc = cfg_cmd_pkg::CC_INVALID;
		end else begin
			cc = cfg_cmd_pkg::CC_PASS;
		end
	end

	assign commit = state == ST_DECIDE && addr_hit && verdict == cfg_cmd_pkg::OUT_OK
		&& wr_format && cc == cfg_cmd_pkg::CC_PASS;

	// Frame check feed: request bytes, then answer data bytes
	always_comb begin
		crc_clear = (state == ST_DECIDE) || (state == ST_SEND && tx_k == tx_last);
		crc_en    = 1'b0;
		crc_data  = link.h2c_byte;
		if (state == ST_RECV) begin
			crc_en = link.h2c_valid;
		end else if (state == ST_SEND && tx_k != 3'h0 && tx_k != tx_last) begin
			crc_en   = 1'b1;
			crc_data = tx_buf[tx_k - 3'h1];
		end
	end

	// Sequencing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= ST_RECV;
			rx_count  <= '0;
			rx_err    <= 1'b0;
			prev_crc  <= cfg_cmd_pkg::CRC_INIT;
			fcs_first <= '0;
			tx_k      <= '0;
			tx_last   <= '0;
		end else begin
			case (state)
				ST_RECV: begin
					if (link.h2c_valid) begin
						rx_count <= (rx_count == cfg_cmd_pkg::OVERFLOW) ? rx_count : rx_count + 4'h1;
						rx_err   <= rx_err | link_fault;
						prev_crc <= crc_value;
						if (link.h2c_last) begin
							state <= ST_DECIDE;
						end
					end
				end
				ST_DECIDE: begin
					rx_count <= '0;
					rx_err   <= 1'b0;
					tx_k     <= '0;
					if (addr_hit) begin
						state <= ST_SEND;
						case (verdict)
							cfg_cmd_pkg::OUT_ABORT:     fcs_first <= crc_value ^ cfg_cmd_pkg::ABORT_XOR;
							cfg_cmd_pkg::OUT_BAD_WRITE: fcs_first <= crc_value ^ cfg_cmd_pkg::BAD_WRITE_XOR;
							default:                    fcs_first <= crc_value;
						endcase
						// Answer length follows the read length field on an OK verdict, otherwise only the first check byte is sent
						tx_last <= (verdict == cfg_cmd_pkg::OUT_OK)
							? rx_buf[cfg_cmd_pkg::POS_RL][2:0] + 3'h1 : 3'h0;
					end else begin
						state <= ST_RECV;
					end
				end
				ST_SEND: begin
					tx_k <= tx_k + 3'h1;
					if (tx_k == tx_last) begin
						state <= ST_RECV;
					end
				end
				default: state <= ST_RECV;
			endcase
		end
	end

	// Request capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < cfg_cmd_pkg::FRAME_DEPTH; i++) begin
				rx_buf[i] <= '0;
			end
		end else if (state == ST_RECV && link.h2c_valid && 32'(rx_count) < cfg_cmd_pkg::FRAME_DEPTH) begin
			rx_buf[rx_count] <= link.h2c_byte;
		end
	end

	// Answer bytes: completion code first, data low byte first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < cfg_cmd_pkg::RESP_BYTES; i++) begin
				tx_buf[i] <= '0;
			end
		end else if (state == ST_DECIDE) begin
			tx_buf[0] <= cc;
			tx_buf[1] <= held_word[7:0];
			tx_buf[2] <= held_word[15:8];
			tx_buf[3] <= held_word[23:16];
			tx_buf[4] <= held_word[31:24];
		end
	end

	// Link outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link.c2h_valid <= 1'b0;
			link.c2h_byte  <= '0;
			link.c2h_last  <= 1'b0;
		end else begin
			link.c2h_valid <= state == ST_SEND;
			link.c2h_last  <= state == ST_SEND && tx_k == tx_last;
			if (tx_k == 3'h0) begin
				link.c2h_byte <= fcs_first;
			end else if (tx_k == tx_last) begin
				link.c2h_byte <= crc_value;
			end else begin
				link.c2h_byte <= tx_buf[tx_k - 3'h1];
			end
		end
	end

	// Configuration space, link writes win over local loads
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				space[i] <= '0;
			end
		end else if (commit) begin
			space[entry_addr(req_index, req_param)] <= req_data;
		end else if (load_valid && entry_valid(load_index, load_param)) begin
			space[entry_addr(load_index, load_param)] <= load_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			upd_valid <= 1'b0;
			upd_index <= '0;
			upd_param <= '0;
			upd_data  <= '0;
		end else begin
			upd_valid <= commit;
			if (commit) begin
				upd_index <= req_index;
				upd_param <= req_param;
				upd_data  <= req_data;
			end
		end
	end
endmodule // cfg_access_client

// *** cfg_access_host.sv ***
// Originator end: Wishbone registers drive configuration read and write requests
module cfg_access_host (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Interrupt
	output logic             irq,
	// Link
	cfg_link_if.host_end     link
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SEND = 2'b01,
		H_RECV = 2'b10
	} host_state_t;

	host_state_t           state;
	logic [31:0]           ctrl;
	logic [31:0]           target;
	logic [31:0]           wdata;
	logic [31:0]           rdata;
	logic [31:0]           originator_identifier;
	logic [7:0]            cc;
	cfg_cmd_pkg::outcome_t outcome;
	cfg_cmd_pkg::outcome_t next_outcome;
	logic                  busy;
	logic [1:0]            int_status;
	logic [1:0]            int_mask;
	logic [3:0]            k;
	logic [2:0]            n;
	logic                  wr_hit;
	logic                  start;
	logic                  is_write;
	logic [3:0]            frame_last;
	logic [7:0]            next_byte;
	logic                  crc_clear;
	logic                  crc_en;
	logic [7:0]            crc_data;
	logic [7:0]            crc_value;
	logic                  done_evt;
	logic                  fail_evt;
	logic [1:0]            clear_bits;
	logic [31:0]           read_word;

	function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = din[b*8 +: 8];
			end
		end
		return r;
	endfunction

	frame_check u_check (
		.clk    (clk),
		.arst_n (arst_n),
		.clear  (crc_clear),
		.enable (crc_en),
		.data   (crc_data),
		.value  (crc_value)
	);

	assign wr_hit     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign start      = wr_hit && wb_adr_i == cfg_cmd_pkg::REG_CTRL && wb_sel_i[0]
		&& wb_dat_i[cfg_cmd_pkg::CTRL_START] && !busy;
	assign is_write   = ctrl[cfg_cmd_pkg::CTRL_WRITE];
	assign frame_last = (is_write ? cfg_cmd_pkg::WR_FRAME : cfg_cmd_pkg::RD_FRAME) - 4'h1;
	assign done_evt   = state == H_RECV && link.c2h_valid && link.c2h_last;
	assign fail_evt   = done_evt && (next_outcome != cfg_cmd_pkg::OUT_OK || cc != cfg_cmd_pkg::CC_PASS);

	// Request bytes, low byte first, assured check last on writes
	always_comb begin
		case (k)
			cfg_cmd_pkg::POS_ADDR:  next_byte = target[7:0];
			cfg_cmd_pkg::POS_WL:    next_byte = is_write ? cfg_cmd_pkg::WR_WL : cfg_cmd_pkg::RD_WL;
			cfg_cmd_pkg::POS_RL:    next_byte = is_write ? cfg_cmd_pkg::WR_RL : cfg_cmd_pkg::RD_RL;
			cfg_cmd_pkg::POS_CMD:   next_byte = is_write ? cfg_cmd_pkg::WR_CMD : cfg_cmd_pkg::RD_CMD;
			cfg_cmd_pkg::POS_ID:    next_byte = {originator_identifier[6:0], ctrl[cfg_cmd_pkg::CTRL_RETRY]};
			cfg_cmd_pkg::POS_INDEX: next_byte = target[15:8];
			cfg_cmd_pkg::POS_PLSB:  next_byte = target[23:16];
			cfg_cmd_pkg::POS_PMSB:  next_byte = target[31:24];
			cfg_cmd_pkg::POS_D0:    next_byte = wdata[7:0];
			cfg_cmd_pkg::POS_D1:    next_byte = wdata[15:8];
			cfg_cmd_pkg::POS_D2:    next_byte = wdata[23:16];
			cfg_cmd_pkg::POS_D3:    next_byte = wdata[31:24];
			cfg_cmd_pkg::POS_AW:    next_byte = crc_value ^ cfg_cmd_pkg::AW_XOR;
			default:                next_byte = '0;
		endcase
	end

	always_comb begin
		crc_clear    = start;
		crc_en       = state == H_SEND;
		crc_data     = state == H_SEND ? next_byte : link.c2h_byte;
		next_outcome = outcome;
		if (state == H_RECV && link.c2h_valid) begin
			if (n == 3'h0) begin
				crc_clear = 1'b1;
				if (link.c2h_byte == crc_value) begin
					next_outcome = cfg_cmd_pkg::OUT_OK;
				end else if (link.c2h_byte == (crc_value ^ cfg_cmd_pkg::ABORT_XOR)) begin
					next_outcome = cfg_cmd_pkg::OUT_ABORT;
				end else begin
					next_outcome = cfg_cmd_pkg::OUT_BAD_WRITE;
				end
			end else if (!link.c2h_last) begin
				crc_en = 1'b1;
			end else if (link.c2h_byte != crc_value && outcome == cfg_cmd_pkg::OUT_OK) begin
				next_outcome = cfg_cmd_pkg::OUT_BAD_READ;
			end
		end
	end

	// Transfer sequencing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state          <= H_IDLE;
			k              <= '0;
			n              <= '0;
			busy           <= 1'b0;
			outcome        <= cfg_cmd_pkg::OUT_OK;
			cc             <= '0;
			rdata          <= '0;
			link.h2c_valid <= 1'b0;
			link.h2c_byte  <= '0;
			link.h2c_last  <= 1'b0;
		end else begin
			link.h2c_valid <= 1'b0;
			link.h2c_last  <= 1'b0;
			outcome        <= next_outcome;
			case (state)
				H_IDLE: begin
					if (start) begin
						state   <= H_SEND;
						busy    <= 1'b1;
						k       <= '0;
						cc      <= '0;
						outcome <= cfg_cmd_pkg::OUT_OK;
					end
				end
				H_SEND: begin
					link.h2c_valid <= 1'b1;
					link.h2c_byte  <= next_byte;
					link.h2c_last  <= k == frame_last;
					k              <= k + 4'h1;
					if (k == frame_last) begin
						state <= H_RECV;
						n     <= '0;
					end
				end
				H_RECV: begin
					if (link.c2h_valid) begin
						n <= n + 3'h1;
						if (n == 3'h1 && !link.c2h_last) begin
							cc <= link.c2h_byte;
						end else if (n != 3'h0 && !link.c2h_last) begin
							rdata <= {link.c2h_byte, rdata[31:8]};
						end
						if (link.c2h_last) begin
							state <= H_IDLE;
							busy  <= 1'b0;
						end
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl     <= '0;
			target   <= '0;
			wdata    <= '0;
			originator_identifier  <= '0;
			int_mask <= '0;
		end else if (wr_hit) begin
			case (wb_adr_i)
				cfg_cmd_pkg::REG_CTRL:     ctrl <= apply_sel(ctrl, wb_dat_i, wb_sel_i) & ~(32'h1 << cfg_cmd_pkg::CTRL_START);
				cfg_cmd_pkg::REG_TARGET:   target <= apply_sel(target, wb_dat_i, wb_sel_i);
				cfg_cmd_pkg::REG_WDATA:    wdata <= apply_sel(wdata, wb_dat_i, wb_sel_i);
				cfg_cmd_pkg::REG_ORIGINATOR_IDENTIFIER:  originator_identifier <= apply_sel(originator_identifier, wb_dat_i, wb_sel_i) & 32'h7f;
				cfg_cmd_pkg::REG_INT_MASK: int_mask <= wb_sel_i[0] ? wb_dat_i[1:0] : int_mask;
				default:                   ctrl <= ctrl;
			endcase
		end
	end

	// Sticky events; a set in the clearing cycle survives
	assign clear_bits = (wr_hit && wb_adr_i == cfg_cmd_pkg::REG_INT_STATUS && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			int_status <= cfg_cmd_pkg::INT_RESET;
			irq        <= 1'b0;
		end else begin
			int_status <= (int_status & ~clear_bits) | {fail_evt, done_evt};
			irq        <= |(int_status & int_mask);
		end
	end

	always_comb begin
		read_word = '0;
		case (wb_adr_i)
			cfg_cmd_pkg::REG_CTRL:       read_word = ctrl;
			cfg_cmd_pkg::REG_TARGET:     read_word = target;
			cfg_cmd_pkg::REG_WDATA:      read_word = wdata;
			cfg_cmd_pkg::REG_RDATA:      read_word = rdata;
			cfg_cmd_pkg::REG_RESULT: begin
				read_word[cfg_cmd_pkg::RES_CC_LSB +: 8]  = cc;
				read_word[cfg_cmd_pkg::RES_OUT_LSB +: 2] = outcome;
				read_word[cfg_cmd_pkg::RES_BUSY]         = busy;
			end
			cfg_cmd_pkg::REG_INT_STATUS: read_word[1:0] = int_status;
			cfg_cmd_pkg::REG_INT_MASK:   read_word[1:0] = int_mask;
			cfg_cmd_pkg::REG_ORIGINATOR_IDENTIFIER:    read_word = originator_identifier;
			default:                     read_word = '0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= read_word;
			end
		end
	end
endmodule // cfg_access_host

// *** cfg_cmd_pkg.sv ***
// Shared constants and types for package configuration access over the management link
package cfg_cmd_pkg;
	// Command formats
	localparam logic [7:0] RD_CMD = 8'ha1;
	localparam logic [7:0] RD_WL  = 8'h05;
	localparam logic [7:0] RD_RL  = 8'h05;
	localparam logic [7:0] WR_CMD = 8'ha5;
	localparam logic [7:0] WR_WL  = 8'h0a;
	localparam logic [7:0] WR_RL  = 8'h01;
	// Completion codes
	localparam logic [7:0] CC_PASS    = 8'h40;
	localparam logic [7:0] CC_TIMEOUT = 8'h80;
	localparam logic [7:0] CC_NO_RES  = 8'h81;
	localparam logic [7:0] CC_INVALID = 8'h90;
	localparam logic [7:0] CC_FAULT   = 8'h91;
	// Frame check
	localparam logic [7:0] CRC_POLY      = 8'h07;
	localparam logic [7:0] CRC_INIT      = 8'h00;
	localparam logic [7:0] AW_XOR        = 8'h80;
	localparam logic [7:0] ABORT_XOR     = 8'hff;
	localparam logic [7:0] BAD_WRITE_XOR = 8'h55;
	// Byte positions within a request frame
	localparam logic [3:0] POS_ADDR  = 4'h0;
	localparam logic [3:0] POS_WL    = 4'h1;
	localparam logic [3:0] POS_RL    = 4'h2;
	localparam logic [3:0] POS_CMD   = 4'h3;
	localparam logic [3:0] POS_ID    = 4'h4;
	localparam logic [3:0] POS_INDEX = 4'h5;
	localparam logic [3:0] POS_PLSB  = 4'h6;
	localparam logic [3:0] POS_PMSB  = 4'h7;
	localparam logic [3:0] POS_D0    = 4'h8;
	localparam logic [3:0] POS_D1    = 4'h9;
	localparam logic [3:0] POS_D2    = 4'ha;
	localparam logic [3:0] POS_D3    = 4'hb;
	localparam logic [3:0] POS_AW    = 4'hc;
	localparam logic [3:0] RD_FRAME  = 4'h8;
	localparam logic [3:0] WR_FRAME  = 4'hd;
	localparam logic [3:0] OVERFLOW  = 4'he;
	localparam int         FRAME_DEPTH = 13;
	localparam int         RESP_BYTES  = 5;
	// Host register offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_TARGET     = 8'h04;
	localparam logic [7:0] REG_WDATA      = 8'h08;
	localparam logic [7:0] REG_RDATA      = 8'h0c;
	localparam logic [7:0] REG_RESULT     = 8'h10;
	localparam logic [7:0] REG_INT_STATUS = 8'h14;
	localparam logic [7:0] REG_INT_MASK   = 8'h18;
	localparam logic [7:0] REG_ORIGINATOR_IDENTIFIER    = 8'h1c;
	// Host register fields
	localparam int CTRL_START     = 0;
	localparam int CTRL_WRITE     = 1;
	localparam int CTRL_RETRY     = 2;
	localparam int RES_CC_LSB     = 0;
	localparam int RES_OUT_LSB    = 8;
	localparam int RES_BUSY       = 16;
	localparam int INT_DONE       = 0;
	localparam int INT_FAIL       = 1;
	localparam logic [1:0] INT_RESET = 2'h0;

	typedef enum logic [1:0] {
		OUT_OK        = 2'b00,
		OUT_ABORT     = 2'b01,
		OUT_BAD_WRITE = 2'b10,
		OUT_BAD_READ  = 2'b11
	} outcome_t;
endpackage

// *** cfg_link_if.sv ***
// Byte link between the originator and the client
interface cfg_link_if;
	logic       h2c_valid;
	logic [7:0] h2c_byte;
	logic       h2c_last;
	logic       c2h_valid;
	logic [7:0] c2h_byte;
	logic       c2h_last;

	modport host_end (output h2c_valid, h2c_byte, h2c_last, input c2h_valid, c2h_byte, c2h_last);
	modport client_end (input h2c_valid, h2c_byte, h2c_last, output c2h_valid, c2h_byte, c2h_last);
endinterface

// *** cfg_link_properties.sv ***
// Protocol properties of the byte link between originator and client
module cfg_link_properties (
	// Clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// Link
	input wire logic       h2c_valid,
	input wire logic [7:0] h2c_byte,
	input wire logic       h2c_last,
	input wire logic       c2h_valid,
	input wire logic [7:0] c2h_byte,
	input wire logic       c2h_last
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] hcnt;
	logic [3:0] ccnt;
	// Byte positions within the current request and answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) hcnt <= 4'h0;
		else if (h2c_valid) hcnt <= h2c_last ? 4'h0 : hcnt + 4'h1;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) ccnt <= 4'h0;
		else if (c2h_valid) ccnt <= c2h_last ? 4'h0 : ccnt + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence quiet_s;
		!c2h_valid [*2];
	endsequence
	sequence first_s;
		c2h_valid && ccnt == 4'h0;
	endsequence
	AST_ANS_LAT: assert property (h2c_valid && h2c_last |=> quiet_s ##1 first_s)
		else $error("answer not on third cycle");
	AST_ANS_CAUSE: assert property ($rose(c2h_valid) |-> $past(h2c_last, 3))
		else $error("answer without request");
	AST_REQ_LEN: assert property (h2c_valid && h2c_last |-> hcnt == 4'h7 || hcnt == 4'hc)
		else $error("request length wrong");
	AST_LENGTHS: assert property (h2c_valid && hcnt == 4'h1 |-> h2c_byte inside {8'h05, 8'h0a})
		else $error("length byte wrong");
	AST_CMD_CODE: assert property (h2c_valid && hcnt == 4'h3 |-> h2c_byte == ($past(h2c_byte, 2) == 8'h05 ? 8'ha1 : 8'ha5))
		else $error("command code wrong");
	AST_CC_SET: assert property (c2h_valid && ccnt == 4'h1 |-> c2h_byte inside {8'h40, 8'h80, 8'h81, 8'h90, 8'h91})
		else $error("completion code unknown");
	AST_ANS_LEN: assert property (c2h_valid && c2h_last |-> ccnt inside {4'h0, 4'h2, 4'h6})
		else $error("answer length wrong");
	AST_ANS_B2B: assert property (c2h_valid && !c2h_last |=> c2h_valid && !h2c_valid)
		else $error("answer broken");
endmodule // cfg_link_properties

// *** frame_check.sv ***
// Running eight-bit frame check over a byte stream
module frame_check (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Stream
	input  wire logic       clear,
	input  wire logic       enable,
	input  wire logic [7:0] data,
	output logic      [7:0] value
);
	function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] din);
		logic [7:0] c;
		c = crc ^ din;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ cfg_cmd_pkg::CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			value <= cfg_cmd_pkg::CRC_INIT;
		end else if (clear) begin
			value <= cfg_cmd_pkg::CRC_INIT;
		end else if (enable) begin
			value <= crc_step(value, data);
		end
	end
endmodule // frame_check

// *** package_config_access_commands_tb.sv ***
// Self-checking bench: originator and client ends joined by the byte link
module package_config_access_commands_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	logic        busy = 1'b0;
	logic        no_resource = 1'b0;
	logic        fault = 1'b0;
	logic        link_fault = 1'b0;
	logic        load_valid = 1'b0;
	logic [7:0]  load_index = 8'h05;
	logic [15:0] load_param = 16'h0002;
	logic [31:0] load_data = 32'hc0de5a17;
	logic        upd_valid;
	logic [31:0] upd_data;
	logic [31:0] upd_seen;
	logic [7:0]  upd_index;
	logic [15:0] upd_param;
	logic [23:0] upd_where;
	logic        retry = 1'b0;
	logic [31:0] mem [0:255];
	logic [31:0] r;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          seed = 38696;
	cfg_link_if link ();
	cfg_access_host i_cfg_access_host (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .irq(irq), .link(link));
	cfg_access_client i_cfg_access_client (.clk, .arst_n, .link(link), .link_fault, .busy, .no_resource, .fault,
		.load_valid, .load_index, .load_param, .load_data, .upd_valid, .upd_index, .upd_param, .upd_data);
	cfg_link_properties i_cfg_link_properties (.clk, .arst_n, .h2c_valid(link.h2c_valid), .h2c_byte(link.h2c_byte),
		.h2c_last(link.h2c_last), .c2h_valid(link.c2h_valid), .c2h_byte(link.c2h_byte), .c2h_last(link.c2h_last));
	always #10 clk = ~clk;
	always @(posedge clk) if (upd_valid) upd_seen <= upd_data;
	always @(posedge clk) if (upd_valid) upd_where <= {upd_param, upd_index};
	task finish_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = rd;
		cyc <= 1'b0;
	endtask
	task op(input logic w, input logic [7:0] i, input logic [15:0] p, input logic [31:0] d);
		logic [7:0] cc;
		logic       ok;
		int         k;
		wb(1'b1, cfg_cmd_pkg::REG_TARGET, {p, i, 8'h30});
		// Service inputs set just before the call have settled by now
		cc = fault ? 8'h91 : busy ? 8'h80 : no_resource ? 8'h81 : (i > 63 || p > 3) ? 8'h90 : 8'h40;
		ok = cc == 8'h40 && !link_fault;
		wb(1'b1, cfg_cmd_pkg::REG_WDATA, d);
		wb(1'b1, cfg_cmd_pkg::REG_CTRL, {29'h0, retry, w, 1'b1});
		k = 0;
		while (irq !== 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		chk(32'(irq), 32'h1);
		wb(1'b0, cfg_cmd_pkg::REG_RESULT, 32'h0);
		chk(32'(rdat[9:0]), {22'h0, link_fault, 1'b0, link_fault ? 8'h00 : cc});
		wb(1'b0, cfg_cmd_pkg::REG_INT_STATUS, 32'h0);
		chk(32'(rdat[1:0]), {30'h0, !ok, 1'b1});
		wb(1'b1, cfg_cmd_pkg::REG_INT_STATUS, 32'h3);
		if (ok && w) mem[{i[5:0], p[1:0]}] = d;
		if (ok && w) chk(upd_seen, d);
		if (ok && w) chk(32'(upd_where), {8'h0, p, i});
		wb(1'b0, cfg_cmd_pkg::REG_RDATA, 32'h0);
		chk(32'(irq), 32'h0);
		if (ok && !w) chk(rdat, mem[{i[5:0], p[1:0]}]);
		retry = cc == 8'h80 || cc == 8'h81;
	endtask
	initial begin
		foreach (mem[j]) mem[j] = 32'h0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		wb(1'b0, cfg_cmd_pkg::REG_RESULT, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, cfg_cmd_pkg::REG_INT_MASK, 32'h1);
		wb(1'b1, cfg_cmd_pkg::REG_ORIGINATOR_IDENTIFIER, 32'hff);
		wb(1'b0, cfg_cmd_pkg::REG_ORIGINATOR_IDENTIFIER, 32'h0);
		chk(rdat, 32'h7f);
		load_valid <= 1'b1;
		@(posedge clk);
		load_valid <= 1'b0;
		mem[22] = 32'hc0de5a17;
		op(1'b0, 8'h05, 16'h0002, 32'h0);
		op(1'b1, 8'h40, 16'h0000, 32'h1234abcd);
		op(1'b0, 8'h03, 16'h0004, 32'h0);
		op(1'b1, 8'h3f, 16'h0003, 32'hfedcba98);
		op(1'b0, 8'h3f, 16'h0003, 32'h0);
		for (int c = 1; c < 6; c++) begin
			{link_fault, fault, no_resource, busy} <= 4'(c < 5 ? 1 << (c - 1) : 0);
			op(1'(c), 8'h01, 16'h0000, 32'h55aa00ff);
		end
		for (int n = 0; n < 40; n++) begin
			r = $random(seed);
			{link_fault, fault, no_resource, busy} <= 4'(r[3:0] < 4 ? 1 << r[1:0] : 0);
			op(1'b1, r[11:4] & 8'h4f, 16'(r[13:12]), $random(seed));
			op(1'b0, r[11:4] & 8'h4f, 16'(r[13:12]), 32'h0);
		end
		finish_test;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		finish_test;
	end
endmodule // package_config_access_commands_tb
